// >>> verilog/alarm_irq_pkg.sv
/*
 * Constants for the per-channel alarm status and interrupt block:
 * register indices, bit positions, reset values and persistence timing.
 * Assumes a single 50 MHz system clock.
 */
package alarm_irq_pkg;

   // Timing
   localparam int unsigned CLK_HZ           = 50_000_000;
   localparam int unsigned CYC_PER_MS       = CLK_HZ / 1000;
   localparam int unsigned ACT_PERSIST_MS   = 40;
   localparam int unsigned DEACT_PERSIST_MS = 30;
   localparam int unsigned AUTO_PERSIST_MS  = 5100;
   localparam int unsigned ACT_PERSIST_CYC   = ACT_PERSIST_MS * CYC_PER_MS;
   localparam int unsigned DEACT_PERSIST_CYC = DEACT_PERSIST_MS * CYC_PER_MS;
   localparam int unsigned AUTO_PERSIST_CYC  = AUTO_PERSIST_MS * CYC_PER_MS;

   // Register indices; byte address is four times the index
   localparam logic [9:0] IDX_EDGE_SEL = 10'h01A;
   localparam logic [9:0] IDX_MASK_A   = 10'h01B;
   localparam logic [9:0] IDX_MASK_B   = 10'h01C;
   localparam logic [9:0] IDX_STATUS_A = 10'h01E;
   localparam logic [9:0] IDX_STATUS_B = 10'h01F;
   localparam logic [9:0] IDX_LATCH_A  = 10'h020;
   localparam logic [9:0] IDX_LATCH_B  = 10'h021;

   // Reset values and the used latch B bits
   localparam logic [7:0] STATUS_RST   = 8'h00;
   localparam logic [7:0] LATCH_RST    = 8'h00;
   localparam logic [7:0] MASK_A_RST   = 8'hFF;
   localparam logic [7:0] MASK_B_RST   = 8'hEF;
   localparam logic [7:0] EDGE_SEL_RST = 8'h00;
   localparam logic [7:0] LATCH_B_USED = 8'hE3;

   // Status A / latch A bit positions
   localparam int unsigned B_AUTO_LOOP   = 7;
   localparam int unsigned B_AMP_OVF     = 7;
   localparam int unsigned B_TX_JIT      = 6;
   localparam int unsigned B_RX_JIT      = 5;
   localparam int unsigned B_OVERCURRENT = 4;
   localparam int unsigned B_CLK_MISSING = 3;
   localparam int unsigned B_TX_LOSS     = 2;
   localparam int unsigned B_SYS_LOSS    = 1;
   localparam int unsigned B_LINE_LOSS   = 0;

   // Status B / latch B bit positions
   localparam int unsigned B_SYS_AIS  = 7;
   localparam int unsigned B_LINE_AIS = 6;
   localparam int unsigned B_PRBS     = 5;
   localparam int unsigned B_ACT_CODE = 1;
   localparam int unsigned B_DEACT    = 0;

   // Edge select bit positions
   localparam int unsigned ES_AIS  = 6;
   localparam int unsigned ES_PRBS = 5;
   localparam int unsigned ES_OC   = 4;
   localparam int unsigned ES_CLK  = 3;
   localparam int unsigned ES_TXL  = 2;
   localparam int unsigned ES_LOS  = 1;
   localparam int unsigned ES_CODE = 0;

endpackage

// >>> verilog/edge_if.sv
/*
 * Carrier between the register block and an edge detector: a status
 * vector, its per-bit edge selects and the resulting one-cycle hits.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
interface edge_if;
   logic [7:0] status;
   logic [7:0] edge_sel;
   logic [7:0] hit;
   modport src (output status, output edge_sel, input hit);
   modport det (input status, input edge_sel, output hit);
endinterface

// >>> verilog/edge_detect.sv
/*
 * Per-bit transition detector. A bit hits on a rising change, or on
 * any change when its edge select is one.
 * Assumes status is registered and synchronous to i_clk.
 */
`timescale 1ns/100ps
module edge_detect (
   // Clock and reset
   input  wire logic i_clk,
   input  wire logic i_arst_n,
   // Status in, hits out
   edge_if.det       port
);
   typedef struct packed {
      logic [7:0] prev;
   } edge_state_t;

   edge_state_t st_r;
   edge_state_t st_nxt;

   always_comb begin
      st_nxt      = st_r;
      st_nxt.prev = port.status;
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         st_r <= '{prev: 8'h00};
      end else begin
         st_r <= st_nxt;
      end
   end

   // Either-direction when selected, else rising only
   assign port.hit = (port.status ^ st_r.prev) & (port.status | port.edge_sel);

   any_edge_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (port.status != $past(port.status))
      |-> (port.hit & port.edge_sel) == ((port.status ^ $past(port.status)) & port.edge_sel))
      else $error("change not reported with edge select set");
   no_fall_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      ((st_r.prev & ~port.status & ~port.edge_sel & port.hit) == 8'h00))
      else $error("falling change hit with rising-only select");
endmodule

// >>> verilog/code_persist.sv
/*
 * Persistence timer for a loop code detector. The flag rises once the
 * code has stood for more than the selected limit and drops with it.
 * Assumes i_present is synchronous to i_clk.
 */
`timescale 1ns/100ps
module code_persist
   import alarm_irq_pkg::*;
#(
   parameter int unsigned SHORT_CYC = ACT_PERSIST_CYC,
   parameter int unsigned LONG_CYC  = AUTO_PERSIST_CYC
) (
   // Clock and reset
   input  wire logic i_clk,
   input  wire logic i_arst_n,
   // Detector
   input  wire logic i_present,
   input  wire logic i_long,
   output logic      o_flag
);
   typedef struct packed {
      logic [31:0] cnt;
      logic        flag;
   } persist_t;

   persist_t    st_r;
   persist_t    st_nxt;
   logic [31:0] limit;

   assign limit = i_long ? 32'(LONG_CYC) : 32'(SHORT_CYC);

   always_comb begin
      st_nxt = st_r;
      if (!i_present) begin
         st_nxt.cnt  = 32'h0;
         st_nxt.flag = 1'b0;
      end else if (st_r.cnt < limit) begin
         st_nxt.cnt = st_r.cnt + 32'h1;
      end else begin
         st_nxt.flag = 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         st_r <= '{cnt: 32'h0, flag: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_flag = st_r.flag;

   flag_rise_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      $rose(o_flag) |-> $past(i_present) && ($past(st_r.cnt) >= $past(limit)))
      else $error("flag rose before persistence limit");
   flag_drop_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      !i_present |=> !o_flag)
      else $error("flag held without the code");
endmodule

// >>> verilog/channel_alarm_status_irq.sv
/*
 * Per-channel alarm status, interrupt latches, masks and edge selects
 * behind a classic Wishbone slave, with one level interrupt output.
 * Assumes all condition inputs are synchronous to i_clk and that the
 * bus master holds a request until it sees ack.
 */
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/100ps
module channel_alarm_status_irq
   import alarm_irq_pkg::*;
#(
   parameter int unsigned ACT_CYC   = ACT_PERSIST_CYC,
   parameter int unsigned DEACT_CYC = DEACT_PERSIST_CYC,
   parameter int unsigned AUTO_CYC  = AUTO_PERSIST_CYC
) (
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_arst_n,
   // Wishbone slave
   input  wire logic        i_wb_cyc,
   input  wire logic        i_wb_stb,
   input  wire logic        i_wb_we,
   input  wire logic [11:0] i_wb_adr,
   input  wire logic [3:0]  i_wb_sel,
   input  wire logic [31:0] i_wb_dat,
   output logic [31:0]      o_wb_dat,
   output logic             o_wb_ack,
   // Channel conditions
   input  wire logic        i_auto_loop_active_flag,
   input  wire logic        i_driver_overcurrent_flag,
   input  wire logic        i_tx_clock_missing_flag,
   input  wire logic        i_tx_signal_loss_flag,
   input  wire logic        i_sys_signal_loss_flag,
   input  wire logic        i_line_signal_loss_flag,
   input  wire logic        i_sys_alarm_ind_flag,
   input  wire logic        i_line_alarm_ind_flag,
   input  wire logic        i_prbs_lock_flag,
   input  wire logic        i_activate_code,
   input  wire logic        i_deactivate_code,
   input  wire logic        i_auto_loop_enable,
   // One-cycle events
   input  wire logic        i_amp_overflow_event,
   input  wire logic        i_tx_jitter_buf_event,
   input  wire logic        i_rx_jitter_buf_event,
   // Interrupt
   output logic             o_irq
);

   typedef struct packed {
      logic [7:0] status_a;
      logic [7:0] status_b;
      logic [7:0] latch_a;
      logic [7:0] latch_b;
      logic [7:0] mask_a;
      logic [7:0] mask_b;
      logic [7:0] edge_sel;
      logic       ack;
      logic [7:0] rdat;
      logic       irq;
   } state_t;

   localparam state_t ST_RST = '{
      status_a: STATUS_RST,
      status_b: STATUS_RST,
      latch_a:  LATCH_RST,
      latch_b:  LATCH_RST,
      mask_a:   MASK_A_RST,
      mask_b:   MASK_B_RST,
      edge_sel: EDGE_SEL_RST,
      ack:      1'b0,
      rdat:     8'h00,
      irq:      1'b0
   };

   state_t     st_r;
   state_t     st_nxt;
   logic       req;
   logic       wr;
   logic [9:0] idx;
   logic       adr_ok;
   logic [7:0] wbyte;
   logic [7:0] rd_byte;
   logic [7:0] set_a;
   logic [7:0] set_b;
   logic [7:0] clr_a;
   logic [7:0] clr_b;
   logic       act_flag;
   logic       deact_flag;

   edge_if ea ();
   edge_if eb ();

   // Spread the shared select bits over the status A positions
   function automatic logic [7:0] sel_a(input logic [7:0] es);
      logic [7:0] s;
      s                = 8'h00;
      s[B_OVERCURRENT] = es[ES_OC];
      s[B_CLK_MISSING] = es[ES_CLK];
      s[B_TX_LOSS]     = es[ES_TXL];
      s[B_SYS_LOSS]    = es[ES_LOS];
      s[B_LINE_LOSS]   = es[ES_LOS];
      return s;
   endfunction

   function automatic logic [7:0] sel_b(input logic [7:0] es);
      logic [7:0] s;
      s             = 8'h00;
      s[B_SYS_AIS]  = es[ES_AIS];
      s[B_LINE_AIS] = es[ES_AIS];
      s[B_PRBS]     = es[ES_PRBS];
      s[B_ACT_CODE] = es[ES_CODE];
      s[B_DEACT]    = es[ES_CODE];
      return s;
   endfunction

   // New events win over a clear in the same cycle
   function automatic logic [7:0] latch_update(input logic [7:0] old,
                                               input logic [7:0] clr,
                                               input logic [7:0] set);
      return (old & ~clr) | set;
   endfunction

   function automatic logic pending(input logic [7:0] lat,
                                    input logic [7:0] msk);
      return |(lat & ~msk);
   endfunction

   // Persistence timers for the loop codes
   code_persist #(
      .SHORT_CYC (ACT_CYC),
      .LONG_CYC  (AUTO_CYC)
   ) u_act (
      .i_clk     (i_clk),
      .i_arst_n  (i_arst_n),
      .i_present (i_activate_code),
      .i_long    (i_auto_loop_enable),
      .o_flag    (act_flag)
   );

   code_persist #(
      .SHORT_CYC (DEACT_CYC),
      .LONG_CYC  (AUTO_CYC)
   ) u_deact (
      .i_clk     (i_clk),
      .i_arst_n  (i_arst_n),
      .i_present (i_deactivate_code),
      .i_long    (i_auto_loop_enable),
      .o_flag    (deact_flag)
   );

   assign ea.status   = st_r.status_a;
   assign ea.edge_sel = sel_a(st_r.edge_sel);
   assign eb.status   = st_r.status_b;
   assign eb.edge_sel = sel_b(st_r.edge_sel);

   edge_detect u_edge_a (
      .i_clk    (i_clk),
      .i_arst_n (i_arst_n),
      .port     (ea)
   );

   edge_detect u_edge_b (
      .i_clk    (i_clk),
      .i_arst_n (i_arst_n),
      .port     (eb)
   );

   // Bus decode; only byte lane 0 carries data
   assign req    = i_wb_cyc & i_wb_stb;
   assign idx    = i_wb_adr[11:2];
   assign wr     = req & i_wb_we & i_wb_sel[0] & ~st_r.ack;
   assign wbyte  = i_wb_dat[7:0];
   assign clr_a  = (wr && idx == IDX_LATCH_A) ? wbyte : 8'h00;
   assign clr_b  = (wr && idx == IDX_LATCH_B) ? wbyte : 8'h00;

   always_comb begin
      rd_byte = 8'h00;
      adr_ok  = 1'b1;
      case (idx)
         IDX_EDGE_SEL: rd_byte = st_r.edge_sel;
         IDX_MASK_A:   rd_byte = st_r.mask_a;
         IDX_MASK_B:   rd_byte = st_r.mask_b;
         IDX_STATUS_A: rd_byte = st_r.status_a;
         IDX_STATUS_B: rd_byte = st_r.status_b;
         IDX_LATCH_A:  rd_byte = st_r.latch_a;
         IDX_LATCH_B:  rd_byte = st_r.latch_b;
         default:      adr_ok  = 1'b0;
      endcase
   end

   always_comb begin
      set_a                = 8'h00;
      set_a[B_AMP_OVF]     = i_amp_overflow_event;
      set_a[B_TX_JIT]      = i_tx_jitter_buf_event;
      set_a[B_RX_JIT]      = i_rx_jitter_buf_event;
      set_a[B_OVERCURRENT] = ea.hit[B_OVERCURRENT];
      set_a[B_CLK_MISSING] = ea.hit[B_CLK_MISSING];
      set_a[B_TX_LOSS]     = ea.hit[B_TX_LOSS];
      set_a[B_SYS_LOSS]    = ea.hit[B_SYS_LOSS];
      set_a[B_LINE_LOSS]   = ea.hit[B_LINE_LOSS];
      set_b                = eb.hit & LATCH_B_USED;
   end

   always_comb begin
      st_nxt = st_r;

      st_nxt.status_a                = STATUS_RST;
      st_nxt.status_a[B_AUTO_LOOP]   = i_auto_loop_active_flag;
      st_nxt.status_a[B_OVERCURRENT] = i_driver_overcurrent_flag;
      st_nxt.status_a[B_CLK_MISSING] = i_tx_clock_missing_flag;
      st_nxt.status_a[B_TX_LOSS]     = i_tx_signal_loss_flag;
      st_nxt.status_a[B_SYS_LOSS]    = i_sys_signal_loss_flag;
      st_nxt.status_a[B_LINE_LOSS]   = i_line_signal_loss_flag;

      st_nxt.status_b                = STATUS_RST;
      st_nxt.status_b[B_SYS_AIS]     = i_sys_alarm_ind_flag;
      st_nxt.status_b[B_LINE_AIS]    = i_line_alarm_ind_flag;
      st_nxt.status_b[B_PRBS]        = i_prbs_lock_flag;
      st_nxt.status_b[B_ACT_CODE]    = act_flag;
      st_nxt.status_b[B_DEACT]       = deact_flag;

      st_nxt.latch_a = latch_update(st_r.latch_a, clr_a, set_a);
      st_nxt.latch_b = latch_update(st_r.latch_b, clr_b, set_b);

      if (wr && idx == IDX_MASK_A) begin
         st_nxt.mask_a = wbyte;
      end
      if (wr && idx == IDX_MASK_B) begin
         st_nxt.mask_b = wbyte;
      end
      if (wr && idx == IDX_EDGE_SEL) begin
         st_nxt.edge_sel = wbyte;
      end

      // Every access, mapped or not, is acknowledged after one cycle
      st_nxt.ack  = req & ~st_r.ack;
      st_nxt.rdat = (req && !st_r.ack && adr_ok) ? rd_byte : 8'h00;

      // Registered from the next latch state so it tracks latch bits exactly
      st_nxt.irq = pending(st_nxt.latch_a, st_nxt.mask_a) |
                   pending(st_nxt.latch_b, st_nxt.mask_b);
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         st_r <= ST_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_wb_dat = {24'h000000, st_r.rdat};
   assign o_wb_ack = st_r.ack;
   assign o_irq    = st_r.irq;

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_arst_n);

   auto_loop_bit_a: assert property (
      ##1 st_r.status_a[B_AUTO_LOOP] == $past(i_auto_loop_active_flag))
      else $error("loopback status bit wrong");
   overcurrent_bit_a: assert property (
      $rose(i_driver_overcurrent_flag) |=> st_r.status_a[B_OVERCURRENT])
      else $error("overcurrent status bit wrong");
   clock_missing_a: assert property (
      ##1 st_r.status_a[B_CLK_MISSING] == $past(i_tx_clock_missing_flag))
      else $error("clock missing status bit wrong");
   tx_loss_bit_a: assert property (
      $fell(i_tx_signal_loss_flag) |=> !st_r.status_a[B_TX_LOSS])
      else $error("transmit loss status bit wrong");
   loss_bits_a: assert property (
      ##1 st_r.status_a[1:0] == {$past(i_sys_signal_loss_flag),
                                $past(i_line_signal_loss_flag)})
      else $error("loss status bits wrong");
   alarm_bits_a: assert property (
      ##1 st_r.status_b[7:6] == {$past(i_sys_alarm_ind_flag), $past(i_line_alarm_ind_flag)})
      else $error("alarm status bits wrong");
   prbs_bit_a: assert property (
      i_prbs_lock_flag [*2] |-> st_r.status_b[B_PRBS])
      else $error("pattern lock status bit wrong");
   code_bits_a: assert property (
      ##1 st_r.status_b[1:0] == {$past(act_flag), $past(deact_flag)})
      else $error("loop code status bits wrong");
   amp_latch_a: assert property (
      i_amp_overflow_event |=> st_r.latch_a[B_AMP_OVF] && (st_r.mask_a[B_AMP_OVF] || o_irq))
      else $error("amplitude overflow not latched");
   jitter_latch_a: assert property (
      i_tx_jitter_buf_event || i_rx_jitter_buf_event
      |=> (!$past(i_tx_jitter_buf_event) || st_r.latch_a[B_TX_JIT]) &&
          (!$past(i_rx_jitter_buf_event) || st_r.latch_a[B_RX_JIT]))
      else $error("jitter buffer event not latched");
   w1c_clear_a: assert property (
      (clr_a[B_AMP_OVF] && !i_amp_overflow_event) |=> !st_r.latch_a[B_AMP_OVF])
      else $error("write one did not clear latch");
   set_wins_a: assert property (
      (clr_a[B_AMP_OVF] && i_amp_overflow_event) |=> st_r.latch_a[B_AMP_OVF])
      else $error("set lost against clear");
   loss_latch_a: assert property (
      (ea.hit[4:0] != 5'h00) |=> (st_r.latch_a[4:0] & $past(ea.hit[4:0])) == $past(ea.hit[4:0]))
      else $error("status change not latched");
   alarm_latch_a: assert property (
      (eb.hit[7:6] != 2'b00) |=> (st_r.latch_b[7:6] & $past(eb.hit[7:6])) == $past(eb.hit[7:6]))
      else $error("alarm change not latched");
   mask_hold_a: assert property (
      !(wr && idx == IDX_MASK_A) |=> $stable(st_r.mask_a))
      else $error("mask changed without a write");
   irq_level_a: assert property (
      o_irq == (pending(st_r.latch_a, st_r.mask_a) | pending(st_r.latch_b, st_r.mask_b)))
      else $error("interrupt level mismatch");
   ack_one_a: assert property (
      o_wb_ack |=> !o_wb_ack)
      else $error("ack held longer than one cycle");
   mask_b_hold_a: assert property (
      !(wr && idx == IDX_MASK_B) |=> $stable(st_r.mask_b))
      else $error("mask B changed without a write");
   latch_b_clear_a: assert property (
      (clr_b != 8'h00) |=> (st_r.latch_b & $past(clr_b) & ~$past(set_b)) == 8'h00)
      else $error("write one did not clear latch B");
   status_spare_a: assert property (
      st_r.status_a[6:5] == 2'b00 && st_r.status_b[4:2] == 3'b000)
      else $error("reserved status bits set");
   // Bus answer: one cycle after the request, data only alongside ack
   ack_latency_a: assert property (
      req && !o_wb_ack |=> o_wb_ack)
      else $error("request not answered in one cycle");
   idle_data_a: assert property (
      !o_wb_ack |-> o_wb_dat == 32'h0000_0000)
      else $error("read data shown outside ack");
endmodule

// >>> test/host_bus_model.sv
/*
 * Host processor model: a classic Wishbone master that issues one
 * single cycle at a time on request of the bench.
 * Assumes the slave answers with ack on a rising edge of i_clk.
 */
`timescale 1ns/100ps
module host_bus_model (
   // Clock
   input  wire logic        i_clk,
   // Request
   output logic             o_cyc,
   output logic             o_stb,
   output logic             o_we,
   output logic [11:0]      o_adr,
   output logic [3:0]       o_sel,
   output logic [31:0]      o_dat,
   // Answer
   input  wire logic [31:0] i_dat,
   input  wire logic        i_ack
);
   logic [7:0] rd_data;

   initial begin
      o_cyc   = 1'b0;
      o_stb   = 1'b0;
      o_we    = 1'b0;
      o_adr   = 12'h000;
      o_sel   = 4'h0;
      o_dat   = 32'h0000_0000;
      rd_data = 8'h00;
   end

   // Waits for ack without limit; the bench watchdog bounds the run
   task automatic xfer(input logic we, input logic [9:0] idx, input logic [7:0] d,
                       input logic [3:0] sel);
      @(posedge i_clk);
      o_cyc <= 1'b1;
      o_stb <= 1'b1;
      o_we  <= we;
      o_adr <= {idx, 2'b00};
      o_sel <= sel;
      o_dat <= {24'h00_0000, d};
      do @(posedge i_clk); while (i_ack !== 1'b1);
      rd_data = i_dat[7:0];
      o_cyc <= 1'b0;
      o_stb <= 1'b0;
      // Idle bus shows fresh garbage, not the last request
      o_adr <= ~o_adr;
      o_dat <= ~o_dat;
   endtask
endmodule

// >>> test/channel_alarm_status_irq_test.sv
/*
 * Self-checking bench for the alarm status and interrupt block.
 * Assumes short persistence limits of 20, 15 and 60 cycles.
 */
`timescale 1ns/100ps
module channel_alarm_status_irq_test
   import alarm_irq_pkg::*;
;
   logic        i_clk;
   logic        i_arst_n;
   logic        cyc;
   logic        stb;
   logic        we;
   logic [11:0] adr;
   logic [3:0]  sel;
   logic [31:0] wdat;
   logic [31:0] rdat;
   logic        ack;
   logic        irq;
   logic [8:0]  flg;
   logic [2:0]  ev;
   logic        act;
   logic        deact;
   logic        auto_en;
   int          num_errors;
   int          check_count;

   // Flags {auto,oc,clk,txl,sys,line,sais,lais,prbs}, status A, status B
   localparam logic [24:0] ROWS [10] = '{
      {9'h100, 8'h80, 8'h00}, {9'h080, 8'h10, 8'h00}, {9'h040, 8'h08, 8'h00},
      {9'h020, 8'h04, 8'h00}, {9'h010, 8'h02, 8'h00}, {9'h008, 8'h01, 8'h00},
      {9'h004, 8'h00, 8'h80}, {9'h002, 8'h00, 8'h40}, {9'h001, 8'h00, 8'h20},
      {9'h000, 8'h00, 8'h00}};

   host_bus_model host (
      .i_clk (i_clk), .o_cyc (cyc), .o_stb (stb), .o_we (we), .o_adr (adr),
      .o_sel (sel), .o_dat (wdat), .i_dat (rdat), .i_ack (ack));

   channel_alarm_status_irq #(.ACT_CYC (20), .DEACT_CYC (15), .AUTO_CYC (60)) DUT (
      .i_clk (i_clk), .i_arst_n (i_arst_n),
      .i_wb_cyc (cyc), .i_wb_stb (stb), .i_wb_we (we), .i_wb_adr (adr),
      .i_wb_sel (sel), .i_wb_dat (wdat), .o_wb_dat (rdat), .o_wb_ack (ack),
      .i_auto_loop_active_flag (flg[8]), .i_driver_overcurrent_flag (flg[7]),
      .i_tx_clock_missing_flag (flg[6]), .i_tx_signal_loss_flag (flg[5]),
      .i_sys_signal_loss_flag (flg[4]), .i_line_signal_loss_flag (flg[3]),
      .i_sys_alarm_ind_flag (flg[2]), .i_line_alarm_ind_flag (flg[1]),
      .i_prbs_lock_flag (flg[0]), .i_activate_code (act),
      .i_deactivate_code (deact), .i_auto_loop_enable (auto_en),
      .i_amp_overflow_event (ev[2]), .i_tx_jitter_buf_event (ev[1]),
      .i_rx_jitter_buf_event (ev[0]), .o_irq (irq));

   initial i_clk = 1'b0;
   always #10 i_clk = ~i_clk;

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic rd(input logic [9:0] idx, input logic [7:0] exp);
      host.xfer(1'b0, idx, 8'h00, 4'hF);
      check(host.rd_data, exp);
   endtask

   task automatic wr(input logic [9:0] idx, input logic [7:0] d);
      host.xfer(1'b1, idx, d, 4'hF);
   endtask

   task automatic final_report;
      $display("checks=%0d errors=%0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Whole sequence needs well under 2000 cycles
   initial begin
      repeat (5000) @(posedge i_clk);
      num_errors++;
      final_report();
   end

   initial begin
      num_errors  = 0;
      check_count = 0;
      i_arst_n = 1'b0;
      flg = 9'h000;
      ev = 3'h0;
      act = 1'b0;
      deact = 1'b0;
      auto_en = 1'b0;
      repeat (12) @(posedge i_clk);
      i_arst_n <= 1'b1;
      rd(IDX_MASK_A, 8'hFF);
      rd(IDX_MASK_B, 8'hEF);
      rd(IDX_LATCH_A, 8'h00);
      rd(IDX_EDGE_SEL, 8'h00);
      for (int i = 0; i < 10; i++) begin
         @(posedge i_clk);
         flg <= ROWS[i][24:16];
         repeat (3) @(posedge i_clk);
         rd(IDX_STATUS_A, ROWS[i][15:8]);
         rd(IDX_STATUS_B, ROWS[i][7:0]);
      end
      // Only rising changes so far; loop activity never raises auto loop
      rd(IDX_LATCH_A, 8'h1F);
      rd(IDX_LATCH_B, 8'hE0);
      for (int k = 0; k < 2; k++) begin
         wr(IDX_EDGE_SEL, (k == 1) ? 8'h5E : 8'h00);
         @(posedge i_clk);
         flg <= 9'h0FE;
         repeat (3) @(posedge i_clk);
         wr(IDX_LATCH_A, 8'hFF);
         wr(IDX_LATCH_B, 8'hFF);
         flg <= 9'h000;
         repeat (3) @(posedge i_clk);
         rd(IDX_LATCH_A, (k == 1) ? 8'h1F : 8'h00);
         rd(IDX_LATCH_B, (k == 1) ? 8'hC0 : 8'h00);
      end
      wr(IDX_LATCH_A, 8'hFF);
      wr(IDX_LATCH_B, 8'hFF);
      @(posedge i_clk);
      ev <= 3'h7;
      @(posedge i_clk);
      ev <= 3'h0;
      rd(IDX_LATCH_A, 8'hE0);
      check({7'h00, irq}, 8'h00);
      wr(IDX_MASK_A, 8'h7F);
      repeat (2) @(posedge i_clk);
      check({7'h00, irq}, 8'h01);
      wr(IDX_LATCH_A, 8'h80);
      repeat (2) @(posedge i_clk);
      check({7'h00, irq}, 8'h00);
      host.xfer(1'b1, IDX_LATCH_A, 8'hFF, 4'hE);
      rd(IDX_LATCH_A, 8'h60);
      wr(IDX_STATUS_A, 8'hFF);
      rd(IDX_STATUS_A, 8'h00);
      rd(10'h3FF, 8'h00);
      // Long limit first, then the short ones
      @(posedge i_clk);
      auto_en <= 1'b1;
      act <= 1'b1;
      deact <= 1'b1;
      repeat (40) @(posedge i_clk);
      rd(IDX_STATUS_B, 8'h00);
      repeat (30) @(posedge i_clk);
      rd(IDX_STATUS_B, 8'h03);
      act <= 1'b0;
      deact <= 1'b0;
      auto_en <= 1'b0;
      repeat (3) @(posedge i_clk);
      act <= 1'b1;
      deact <= 1'b1;
      repeat (17) @(posedge i_clk);
      rd(IDX_STATUS_B, 8'h01);
      repeat (10) @(posedge i_clk);
      rd(IDX_STATUS_B, 8'h03);
      rd(IDX_LATCH_B, 8'h03);
      // Falling changes on the pattern and code bits, either edge selected
      flg <= 9'h001;
      wr(IDX_EDGE_SEL, 8'h21);
      wr(IDX_LATCH_B, 8'hFF);
      act <= 1'b0;
      deact <= 1'b0;
      flg <= 9'h000;
      repeat (4) @(posedge i_clk);
      rd(IDX_LATCH_B, 8'h23);
      wr(IDX_MASK_B, 8'hFC);
      repeat (2) @(posedge i_clk);
      check({7'h00, irq}, 8'h01);
      // Reset in mid-run must bring back the reset values of ack, irq, both masks and latch B
      i_arst_n <= 1'b0;
      repeat (2) @(posedge i_clk);
      check({6'h00, ack, irq}, 8'h00);
      i_arst_n <= 1'b1;
      rd(IDX_MASK_A, 8'hFF);
      rd(IDX_MASK_B, 8'hEF);
      rd(IDX_LATCH_B, 8'h00);
      final_report();
   end
endmodule
